/* rtl/supervisor_pkg.sv */
// constants and types for the supply supervisor
package supervisor_pkg;
	// clock rate and comparator reaction time
	localparam int CLK_MHZ = 125;
	localparam int REACT_NS = 3000;
	localparam int REACT_CYC = (REACT_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [1:0] GOOD_TARGET = 2'h3;
	localparam logic [1:0] MISS_TARGET = 2'h3;
	// watchdog phases, gray along the usual path
	typedef enum logic [2:0] {
		PH_POR = 3'h0,
		PH_CLOSED = 3'h1,
		PH_OPEN = 3'h3,
		PH_WDRES = 3'h2,
		PH_SLEEP_WAIT = 3'h6,
		PH_SLEEP_PULSE = 3'h7
	} phase_t;
	// outputs carried together
	typedef struct packed {
		logic resetOutN;
		logic enableOutN;
		logic sleeping;
	} sup_out_t;
endpackage

/* rtl/supply_supervisor.sv */
// supply supervisor with windowed watchdog and sleep detector
`timescale 1ns/1ps
module supply_supervisor #(
	parameter logic [15:0] POR_TICKS = 16'h0064, // power-on delay in ticks
	parameter logic [15:0] CW_TICKS = 16'h0050, // closed window ticks
	parameter logic [15:0] OW_TICKS = 16'h0028, // open window ticks
	parameter logic [15:0] WDR_TICKS = 16'h0003, // reset pulse width ticks
	parameter logic [15:0] SLP_PERIOD_TICKS = 16'h0064, // sleep period on slow tick
	parameter logic [15:0] SLP_PULSE_TICKS = 16'h0001, // sleep pulse on slow tick
	parameter bit QUARTER_POR = 1'b0, // short-delay variant
	parameter bit SLEEP_ENABLE = 1'b1 // sleep-detector variant
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic tick, // resistor-set timebase enable
	input wire logic slowTick, // internal slow timebase enable
	input wire logic monitorAboveRef, // comparator: input above reference
	input wire logic watchdog_clear_n, // clear input from controller
	output supervisor_pkg::sup_out_t supOut
);
	import supervisor_pkg::*;

	// synchroniser stages and edge history
	logic clrS1_reg, clrS2_reg, clrS3_reg;
	logic cmpS1_reg, cmpS2_reg;
	logic [8:0] reactCnt_reg; // reaction filter counter, wide enough for the full reaction time
	logic supplyOk_reg; // filtered comparator
	phase_t phase_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [1:0] good_reg; // consecutive good clears
	logic [1:0] miss_reg; // consecutive unanswered periods
	logic enaN_reg;
	logic clrFall, clrEdge, timeTick, cntDone;
	logic [CNT_W-1:0] porLoad;

	always_ff @(posedge mclk) begin
		if (srst) begin
			clrS1_reg <= 1'b1;
			clrS2_reg <= 1'b1;
			clrS3_reg <= 1'b1;
			cmpS1_reg <= 1'b0;
			cmpS2_reg <= 1'b0;
		end else begin
			clrS1_reg <= watchdog_clear_n;
			clrS2_reg <= clrS1_reg;
			clrS3_reg <= clrS2_reg;
			cmpS1_reg <= monitorAboveRef;
			cmpS2_reg <= cmpS1_reg;
		end
	end
	assign clrFall = clrS3_reg & ~clrS2_reg;
	assign clrEdge = clrS3_reg ^ clrS2_reg;

	// comparator result must persist for the reaction time
	always_ff @(posedge mclk) begin
		if (srst) begin
			reactCnt_reg <= 9'h000;
			supplyOk_reg <= 1'b0;
		end else if (cmpS2_reg == supplyOk_reg) begin
			reactCnt_reg <= 9'h000;
		end else if (reactCnt_reg == 9'(REACT_CYC - 1)) begin
			reactCnt_reg <= 9'h000;
			supplyOk_reg <= cmpS2_reg;
		end else begin
			reactCnt_reg <= reactCnt_reg + 9'h001;
		end
	end

	// power-on delay, quarter in short variant
	assign porLoad = QUARTER_POR ? (POR_TICKS >> 2) : POR_TICKS;
	// sleep phases use the slow timebase, others the resistor one
	assign timeTick = (phase_reg == PH_SLEEP_WAIT || phase_reg == PH_SLEEP_PULSE) ? slowTick : tick;
	assign cntDone = (cnt_reg == CNT_ONE) || (cnt_reg == CNT_ZERO);

	// watchdog phase sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			phase_reg <= PH_POR;
			cnt_reg <= CNT_ZERO;
			miss_reg <= 2'h0;
		end else if (!supplyOk_reg) begin
			// low input holds reset and rearms delay
			phase_reg <= PH_POR;
			cnt_reg <= porLoad;
			miss_reg <= 2'h0;
		end else begin
			case (phase_reg)
				PH_POR: begin
					if (tick && cntDone) begin
						phase_reg <= PH_CLOSED;
						cnt_reg <= CW_TICKS;
					end else if (tick) begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				PH_CLOSED: begin
					if (clrFall) begin
						phase_reg <= PH_WDRES;
						cnt_reg <= WDR_TICKS;
						miss_reg <= 2'h0;
					end else if (tick && cntDone) begin
						phase_reg <= PH_OPEN;
						cnt_reg <= OW_TICKS;
					end else if (tick) begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				PH_OPEN: begin
					if (clrFall) begin
						phase_reg <= PH_CLOSED;
						cnt_reg <= CW_TICKS;
						miss_reg <= 2'h0;
					end else if (tick && cntDone) begin
						phase_reg <= PH_WDRES;
						cnt_reg <= WDR_TICKS;
						// only missed windows count towards sleep
						miss_reg <= miss_reg + 2'h1;
					end else if (tick) begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				PH_WDRES: begin
					if (tick && cntDone) begin
						// third unanswered period ends in sleep
						if (SLEEP_ENABLE && miss_reg == MISS_TARGET) begin
							phase_reg <= PH_SLEEP_WAIT;
							cnt_reg <= SLP_PERIOD_TICKS;
						end else begin
							phase_reg <= PH_CLOSED;
							cnt_reg <= CW_TICKS;
						end
					end else if (tick) begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				PH_SLEEP_WAIT, PH_SLEEP_PULSE: begin
					if (clrEdge) begin
						// any clear edge wakes into closed window
						phase_reg <= PH_CLOSED;
						cnt_reg <= CW_TICKS;
						miss_reg <= 2'h0;
					end else if (slowTick && cntDone) begin
						phase_reg <= (phase_reg == PH_SLEEP_WAIT) ? PH_SLEEP_PULSE : PH_SLEEP_WAIT;
						cnt_reg <= (phase_reg == PH_SLEEP_WAIT) ? SLP_PULSE_TICKS : SLP_PERIOD_TICKS;
					end else if (timeTick) begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				default: begin
					phase_reg <= PH_POR;
					cnt_reg <= porLoad;
				end
			endcase
		end
	end

	// enable after three consecutive good clears
	always_ff @(posedge mclk) begin
		if (srst) begin
			good_reg <= 2'h0;
			enaN_reg <= 1'b1;
		end else if (!supplyOk_reg || phase_reg == PH_POR || phase_reg == PH_WDRES
				|| phase_reg == PH_SLEEP_PULSE || phase_reg == PH_SLEEP_WAIT) begin
			good_reg <= 2'h0;
			enaN_reg <= 1'b1;
		end else if (phase_reg == PH_OPEN && clrFall) begin
			if (good_reg == GOOD_TARGET - 2'h1) begin
				enaN_reg <= 1'b0;
			end
			if (good_reg != GOOD_TARGET) begin
				good_reg <= good_reg + 2'h1;
			end
		end else if (phase_reg == PH_CLOSED && clrFall) begin
			good_reg <= 2'h0;
			enaN_reg <= 1'b1;
		end
	end

	// outputs: reset low in delay, pulse phases or low supply
	logic resN;
	assign resN = supplyOk_reg && !(phase_reg == PH_POR || phase_reg == PH_WDRES || phase_reg == PH_SLEEP_PULSE);
	assign supOut.resetOutN = resN;
	assign supOut.enableOutN = enaN_reg | ~resN;
	assign supOut.sleeping = (phase_reg == PH_SLEEP_WAIT) || (phase_reg == PH_SLEEP_PULSE);

	// low filtered supply always means reset low
	property p_lowSupply;
		@(posedge mclk) disable iff (srst) !supplyOk_reg |=> (phase_reg == PH_POR && !supOut.resetOutN);
	endproperty
	a_lowSupply: assert property (p_lowSupply) else $error("reset high with low supply");
	// enable never active while reset active
	property p_enaReset;
		@(posedge mclk) disable iff (srst) !supOut.resetOutN |-> supOut.enableOutN ##1 enaN_reg;
	endproperty
	a_enaReset: assert property (p_enaReset) else $error("enable active during reset");
	// closed-window clear leads to reset pulse
	property p_early;
		@(posedge mclk) disable iff (srst) (phase_reg == PH_CLOSED && clrFall && supplyOk_reg) |=> !supOut.resetOutN;
	endproperty
	a_early: assert property (p_early) else $error("early clear gave no reset");
	// power-on phase stays put without tick
	property p_porHold;
		@(posedge mclk) disable iff (srst) (phase_reg == PH_POR && supplyOk_reg && !tick) |=> phase_reg == PH_POR;
	endproperty
	a_porHold: assert property (p_porHold) else $error("power-on delay left early");
	// clear edge in sleep wakes next cycle
	property p_wake;
		@(posedge mclk) disable iff (srst) (supOut.sleeping && clrEdge && supplyOk_reg) |=> phase_reg == PH_CLOSED;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep not left on clear edge");
	// a filtered level change always takes the synchronised comparator level of the cycle before
	property p_react;
		@(posedge mclk) disable iff (srst) $changed(supplyOk_reg) |-> $past(cmpS2_reg, 1) == supplyOk_reg;
	endproperty
	a_react: assert property (p_react) else $error("filter changed without input");
	// filtered level moves only after the full reaction count
	property p_reactTime;
		@(posedge mclk) disable iff (srst) $changed(supplyOk_reg) |-> $past(reactCnt_reg) == 9'(REACT_CYC - 1);
	endproperty
	a_reactTime: assert property (p_reactTime) else $error("filter changed before reaction time");
	// open window expiry leads to reset pulse
	property p_miss;
		@(posedge mclk) disable iff (srst) (phase_reg == PH_OPEN && tick && cntDone && !clrFall && supplyOk_reg)
			|=> phase_reg == PH_WDRES;
	endproperty
	a_miss: assert property (p_miss) else $error("missed window gave no reset");
	// sleep entered only after unanswered periods
	property p_sleepEntry;
		@(posedge mclk) disable iff (srst) (phase_reg == PH_SLEEP_WAIT && $past(phase_reg) == PH_WDRES) |-> miss_reg == MISS_TARGET;
	endproperty
	a_sleepEntry: assert property (p_sleepEntry) else $error("sleep entered too soon");
endmodule

/* tb/mcu_model.sv */
// microcontroller model driving the watchdog clear pin
`timescale 1ns/1ps
module mcu_model (
	input wire logic mclk,
	input wire logic serviceReq, // one-cycle request for a clear pulse
	output logic watchdog_clear_n
);
	logic [1:0] lowCnt; // low cycles left
	initial lowCnt = 2'h0;
	always @(posedge mclk) begin
		if (serviceReq) begin
			lowCnt <= 2'h3;
		end else if (lowCnt != 2'h0) begin
			lowCnt <= lowCnt - 2'h1;
		end
	end
	// pin is driven high while no low cycles are left
	assign watchdog_clear_n = (lowCnt == 2'h0);
endmodule

/* tb/supply_supervisor_bench.sv */
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_bench;
	import supervisor_pkg::*;
	logic mclk = 1'b0; // 125 MHz clock
	logic srst = 1'b1; // sync reset
	logic tick = 1'b0; // fast timebase
	logic slowTick = 1'b0; // sleep timebase
	logic monitorAboveRef = 1'b0; // comparator level
	logic serviceReq = 1'b0; // asks model for a clear
	logic clearN; // clear pin
	sup_out_t supOut; // outputs: [2] reset, [1] enable, [0] sleep
	logic [3:0] tcnt = 4'h0; // timebase divider
	int mismatches = 0;
	int comparisons = 0;
	int seed = 22949;
	int i;
	always #4 mclk = ~mclk;
	// fast tick every 4 cycles, slow tick every 8
	always @(posedge mclk) begin
		tcnt <= #1 tcnt + 4'h1;
		tick <= #1 (tcnt[1:0] == 2'h2);
		slowTick <= #1 (tcnt[2:0] == 3'h6);
	end
	supply_supervisor #(.POR_TICKS(16'h0004), .CW_TICKS(16'h0002), .OW_TICKS(16'h0006),
		.WDR_TICKS(16'h0001), .SLP_PERIOD_TICKS(16'h0004)) dut_u (.mclk(mclk), .srst(srst), .tick(tick),
		.slowTick(slowTick), .monitorAboveRef(monitorAboveRef), .watchdog_clear_n(clearN),
		.supOut(supOut));
	mcu_model mcu_u (.mclk(mclk), .serviceReq(serviceReq), .watchdog_clear_n(clearN));
	// verdict and end of run
	task end_of_test;
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// compare one output bit
	task check(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t output bit differs", $time);
		end
	endtask
	// bounded wait for an output bit level
	task waitFor(input int sel, input logic exp, input int bound);
		int n;
		n = 0;
		while (supOut[sel] !== exp && n < bound) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(supOut[sel], exp);
		if (supOut[sel] !== exp) end_of_test();
	endtask
	// count fast ticks
	task ticks(input int n);
		int w;
		repeat (n) begin
			w = 0;
			@(posedge mclk);
			while (tick !== 1'b1 && w < 8) begin
				@(posedge mclk);
				w++;
			end
			if (tick !== 1'b1) begin
				mismatches++;
				$display("mismatch %0t timebase tick missing", $time);
				end_of_test();
			end
		end
		#1;
	endtask
	// one clear pulse from the model
	task service;
		@(posedge mclk);
		serviceReq <= #1 1'b1;
		@(posedge mclk);
		serviceReq <= #1 1'b0;
		#1;
	endtask
	// clear at a random point inside the open window
	task goodClear;
		ticks(4 + ($unsigned($random(seed)) % 3));
		service();
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge mclk);
		srst <= #1 1'b0;
		repeat (50) @(posedge mclk);
		#1;
		check(supOut.resetOutN, 1'b0);
		monitorAboveRef = 1'b1;
		waitFor(2, 1'b1, 450);
		for (i = 0; i < 2; i++) goodClear();
		// short pause keeps the third clear inside its open window
		repeat (4) @(posedge mclk);
		#1;
		check(supOut.enableOutN, 1'b1);
		goodClear();
		waitFor(1, 1'b0, 10);
		service();
		waitFor(2, 1'b0, 8);
		check(supOut.enableOutN, 1'b1);
		waitFor(0, 1'b1, 300);
		waitFor(2, 1'b0, 80);
		waitFor(2, 1'b1, 40);
		service();
		waitFor(0, 1'b0, 10);
		// supply drop: reset must stay low, not just pulse
		monitorAboveRef = 1'b0;
		repeat (REACT_CYC + 12) @(posedge mclk);
		#1;
		check(supOut.resetOutN, 1'b0);
		check(supOut.enableOutN, 1'b1);
		service();
		repeat (16) @(posedge mclk);
		#1;
		check(supOut.resetOutN, 1'b0);
		check(supOut.sleeping, 1'b0);
		// recovery: clear lands inside the power-on delay
		monitorAboveRef = 1'b1;
		repeat (REACT_CYC + 4) @(posedge mclk);
		service();
		check(supOut.resetOutN, 1'b0);
		waitFor(2, 1'b1, 60);
		check(supOut.enableOutN, 1'b1);
		end_of_test();
	end
endmodule
